// ### logic/dof_pkg.sv
// constants for the discrete output force timer block
package dof_pkg;
	// register byte offsets on the bus
	localparam logic [4:0]  REG_CTRL       = 5'h00;
	localparam logic [4:0]  REG_MIN_OFF    = 5'h04;
	localparam logic [4:0]  REG_MIN_ON     = 5'h08;
	localparam logic [4:0]  REG_DELAY      = 5'h0C;
	localparam logic [4:0]  REG_RETAIN     = 5'h10;
	localparam logic [4:0]  REG_STATUS     = 5'h14;
	// control register fields
	localparam int          CTRL_INVERT    = 0;
	localparam int          CTRL_RET_GO    = 1;
	localparam int          CTRL_DLY_GO    = 2;
	// retained force fields
	localparam int          RET_LVL_LSB    = 0;
	localparam int          RET_STATE      = 4;
	// status register fields
	localparam int          ST_OUT         = 0;
	localparam int          ST_HW          = 1;
	localparam int          ST_OFF_RUN     = 2;
	localparam int          ST_ON_RUN      = 3;
	localparam int          ST_DLY_RUN     = 4;
	localparam int          ST_HOLD        = 5;
	localparam int          ST_LVL_LSB     = 8;
	localparam int          ST_ACK         = 12;
	localparam int          ST_INSUF       = 13;
	// widths
	localparam int          SEC_W          = 12;
	localparam int          LVL_W          = 4;
	// precedence levels
	localparam logic [3:0]  LVL_NONE       = 4'h0;
	localparam logic [3:0]  LVL_LAST_HARD  = 4'h5;
	localparam logic [3:0]  LVL_LAST       = 4'hA;
	// reset values and duration limit
	localparam logic [11:0] MIN_OFF_RST    = 12'h000;
	localparam logic [11:0] MIN_ON_RST     = 12'h000;
	localparam logic [11:0] DELAY_RST      = 12'h000;
	localparam logic [11:0] SEC_MAX        = 12'hE10;
	localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
	// timing
	localparam longint      CLK_HZ         = 10_000_000;
	localparam longint      TICK_S         = 1;
	localparam int          TICK_CYCLES    = int'(CLK_HZ * TICK_S);
	// bus handshake state
	typedef enum logic [0:0]
	{
		BUS_IDLE = 1'b0,
		BUS_DONE = 1'b1
	} dof_bus_e;
endpackage

// ### logic/dof_top.sv
// discrete output point: force arbitration, min on/off and delay timers, polarity
//
// Behaviour
// - levels 1 to 5 apply at once and stop min-on and min-off timers.
// - levels 6 to 10 are checked against min-off and min-on timers first.
// - qualified off-to-on with min-off expired: apply, ack, start min-on.
// - qualified turn-on while min-off runs: not-ack with insufficient priority.
// - qualified force leaving output on: apply, ack, min-on timer untouched.
// - qualified on-to-off with min-on expired: apply, ack, start min-off.
// - qualified turn-off while min-on runs: ack with insufficient priority.
// - qualified force leaving output off: apply, ack, min-off timer untouched.
// - forces skip the delay timer and stop it whenever they arrive.
// - delay cancel covers network forces and retained forces after power-up.
// - auto clears the force; output holds until algorithm changes, new force or another auto.
// - polarity normal maps 1 to on; inverted maps 1 to off.
// - min-on seconds programmable, 0 to 3600, default 0.
// - delay seconds before algorithm turn-on, also after power-up; not for forces.
`timescale 1ns/10ps
`default_nettype none
module dof_top
	import dof_pkg::*;
#(
	parameter int TICK_CYCLES_P = dof_pkg::TICK_CYCLES
)
(
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        rstn,
	// avalon-mm slave
	input  wire logic [4:0]                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	// control algorithm
	input  wire logic                        alg_req,
	// network command source
	input  wire logic                        force_valid,
	input  wire logic [dof_pkg::LVL_W-1:0]   force_level,
	input  wire logic                        force_state,
	input  wire logic                        auto_cmd,
	output logic                             rsp_valid,
	output logic                             rsp_ack,
	output logic                             rsp_insuf,
	// hardware output driver
	output logic                             do_out
);
	import dof_pkg::*;

	function automatic logic [SEC_W-1:0] count_down(input logic [SEC_W-1:0] c, input logic tick);
		count_down = (tick && c != '0) ? c - 12'h001 : c;
	endfunction

	function automatic logic [SEC_W-1:0] clamp_sec(input logic [31:0] d);
		clamp_sec = (d[31:12] != '0 || d[11:0] > SEC_MAX) ? SEC_MAX : d[11:0];
	endfunction

	dof_bus_e          bus_r;
	logic              invert_r;
	logic              ret_pend_r;
	logic              dly_go_r;
	logic [SEC_W-1:0]  min_off_r;
	logic [SEC_W-1:0]  min_on_r;
	logic [SEC_W-1:0]  delay_r;
	logic [LVL_W-1:0]  ret_lvl_r;
	logic              ret_state_r;
	logic [SEC_W-1:0]  off_cnt_r;
	logic [SEC_W-1:0]  on_cnt_r;
	logic [SEC_W-1:0]  dly_cnt_r;
	logic [23:0]       tick_cnt_r;
	logic              tick_r;
	logic              init_r;
	logic              alg_q_r;
	logic              out_r;
	logic [LVL_W-1:0]  lvl_r;
	logic              hold_r;
	logic              last_ack_r;
	logic              last_insuf_r;
	logic              wr_go;
	logic              rd_go;
	logic [31:0]       rdata_nxt;

	// bus handshake: one wait cycle, then the access completes
	assign wr_go = avs_write && bus_r == BUS_DONE;
	assign rd_go = avs_read && bus_r == BUS_IDLE;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			bus_r <= BUS_IDLE;
		else if ((avs_read || avs_write) && bus_r == BUS_IDLE)
			bus_r <= BUS_DONE;
		else
			bus_r <= BUS_IDLE;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !((avs_read || avs_write) && bus_r == BUS_IDLE);
	end

	always_comb
	begin
		rdata_nxt = RDATA_ZERO;
		case (avs_address)
			REG_CTRL:    rdata_nxt[CTRL_INVERT] = invert_r;
			REG_MIN_OFF: rdata_nxt[SEC_W-1:0] = min_off_r;
			REG_MIN_ON:  rdata_nxt[SEC_W-1:0] = min_on_r;
			REG_DELAY:   rdata_nxt[SEC_W-1:0] = delay_r;
			REG_RETAIN:
			begin
				rdata_nxt[RET_LVL_LSB +: LVL_W] = ret_lvl_r;
				rdata_nxt[RET_STATE]            = ret_state_r;
			end
			REG_STATUS:
			begin
				rdata_nxt[ST_OUT]              = out_r;
				rdata_nxt[ST_HW]               = do_out;
				rdata_nxt[ST_OFF_RUN]          = off_cnt_r != '0;
				rdata_nxt[ST_ON_RUN]           = on_cnt_r != '0;
				rdata_nxt[ST_DLY_RUN]          = dly_cnt_r != '0;
				rdata_nxt[ST_HOLD]             = hold_r;
				rdata_nxt[ST_LVL_LSB +: LVL_W] = lvl_r;
				rdata_nxt[ST_ACK]              = last_ack_r;
				rdata_nxt[ST_INSUF]            = last_insuf_r;
			end
			default:     rdata_nxt = RDATA_ZERO;
		endcase
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			avs_readdata <= RDATA_ZERO;
		else if (rd_go)
			avs_readdata <= rdata_nxt;
	end

	// configuration registers; durations above the top of range are clamped
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			invert_r    <= 1'b0;
			min_off_r   <= MIN_OFF_RST;
			min_on_r    <= MIN_ON_RST;
			delay_r     <= DELAY_RST;
			ret_lvl_r   <= LVL_NONE;
			ret_state_r <= 1'b0;
		end
		else if (wr_go)
		begin
			case (avs_address)
				REG_CTRL:    invert_r <= avs_writedata[CTRL_INVERT];
				REG_MIN_OFF: min_off_r <= clamp_sec(avs_writedata);
				REG_MIN_ON:  min_on_r <= clamp_sec(avs_writedata);
				REG_DELAY:   delay_r <= clamp_sec(avs_writedata);
				REG_RETAIN:
				begin
					ret_lvl_r   <= avs_writedata[RET_LVL_LSB +: LVL_W];
					ret_state_r <= avs_writedata[RET_STATE];
				end
				default:     invert_r <= invert_r;
			endcase
		end
	end

	// one-second tick
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end
		else if (tick_cnt_r == 24'(TICK_CYCLES_P - 1))
		begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_r + 24'h00_0001;
			tick_r     <= 1'b0;
		end
	end

	// force evaluation
	logic             evt_force;
	logic [LVL_W-1:0] evt_lvl;
	logic             evt_state;
	logic             out_nxt;
	logic [LVL_W-1:0] lvl_nxt;
	logic             hold_nxt;
	logic             start_on;
	logic             start_off;
	logic             stop_min;
	logic             ack_nxt;
	logic             insuf_nxt;
	logic             alg_edge;
	logic             dly_load;

	// a network force this cycle takes the slot; a retained one waits until force_valid is low
	assign evt_force = force_valid || ret_pend_r;
	assign evt_lvl   = force_valid ? force_level : ret_lvl_r;
	assign evt_state = force_valid ? force_state : ret_state_r;
	assign alg_edge  = alg_req != alg_q_r;
	assign dly_load  = dly_go_r || (alg_req && !alg_q_r);

	always_comb
	begin
		out_nxt   = out_r;
		lvl_nxt   = lvl_r;
		hold_nxt  = hold_r && !alg_edge;
		start_on  = 1'b0;
		start_off = 1'b0;
		stop_min  = 1'b0;
		ack_nxt   = 1'b0;
		insuf_nxt = 1'b0;
		if (evt_force)
		begin
			hold_nxt = 1'b0;
			if (evt_lvl == LVL_NONE || evt_lvl > LVL_LAST)
			begin
				ack_nxt = 1'b0;
			end
			else if (lvl_r != LVL_NONE && evt_lvl > lvl_r)
			begin
				insuf_nxt = 1'b1;
			end
			else if (evt_lvl <= LVL_LAST_HARD)
			begin
				out_nxt  = evt_state;
				lvl_nxt  = evt_lvl;
				stop_min = 1'b1;
				ack_nxt  = 1'b1;
			end
			else if (evt_state && !out_r)
			begin
				if (off_cnt_r == '0)
				begin
					out_nxt  = 1'b1;
					lvl_nxt  = evt_lvl;
					start_on = 1'b1;
					ack_nxt  = 1'b1;
				end
				else
					insuf_nxt = 1'b1;
			end
			else if (evt_state)
			begin
				lvl_nxt = evt_lvl;
				ack_nxt = 1'b1;
			end
			else if (out_r)
			begin
				if (on_cnt_r == '0)
				begin
					out_nxt   = 1'b0;
					lvl_nxt   = evt_lvl;
					start_off = 1'b1;
					ack_nxt   = 1'b1;
				end
				else
				begin
					ack_nxt   = 1'b1;
					insuf_nxt = 1'b1;
				end
			end
			else
			begin
				lvl_nxt = evt_lvl;
				ack_nxt = 1'b1;
			end
		end
		else if (auto_cmd)
		begin
			lvl_nxt  = LVL_NONE;
			hold_nxt = lvl_r != LVL_NONE;
		end
		else if (lvl_r == LVL_NONE && !hold_r)
		begin
			// the delay counter loads on this same edge, so a fresh request must not slip past it
			if (alg_req && !out_r && off_cnt_r == '0 && dly_cnt_r == '0 && !init_r
				&& !(dly_load && delay_r != '0))
			begin
				out_nxt  = 1'b1;
				start_on = 1'b1;
			end
			else if (!alg_req && out_r && on_cnt_r == '0)
			begin
				out_nxt   = 1'b0;
				start_off = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			out_r   <= 1'b0;
			lvl_r   <= LVL_NONE;
			hold_r  <= 1'b0;
			alg_q_r <= 1'b0;
			do_out  <= 1'b0;
		end
		else
		begin
			out_r   <= out_nxt;
			lvl_r   <= lvl_nxt;
			hold_r  <= hold_nxt;
			alg_q_r <= alg_req;
			do_out  <= out_nxt ^ invert_r;
		end
	end

	// retained force is replayed after a power-up by software through the control register
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ret_pend_r <= 1'b0;
			dly_go_r   <= 1'b0;
		end
		else
		begin
			ret_pend_r <= (wr_go && avs_address == REG_CTRL && avs_writedata[CTRL_RET_GO])
				|| (ret_pend_r && force_valid);
			dly_go_r   <= wr_go && avs_address == REG_CTRL && avs_writedata[CTRL_DLY_GO];
		end
	end

	// response strobe, one cycle after evaluation
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rsp_valid    <= 1'b0;
			rsp_ack      <= 1'b0;
			rsp_insuf    <= 1'b0;
			last_ack_r   <= 1'b0;
			last_insuf_r <= 1'b0;
		end
		else
		begin
			rsp_valid <= force_valid;
			rsp_ack   <= force_valid && ack_nxt;
			rsp_insuf <= force_valid && insuf_nxt;
			if (evt_force)
			begin
				last_ack_r   <= ack_nxt;
				last_insuf_r <= insuf_nxt;
			end
		end
	end

	// timers; a zero duration loads zero, which reads as expired
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			off_cnt_r <= '0;
			on_cnt_r  <= '0;
		end
		else if (stop_min)
		begin
			off_cnt_r <= '0;
			on_cnt_r  <= '0;
		end
		else
		begin
			off_cnt_r <= start_off ? min_off_r : count_down(off_cnt_r, tick_r);
			on_cnt_r  <= start_on ? min_on_r : count_down(on_cnt_r, tick_r);
		end
	end

	// delay restarts at power-up and on each algorithm turn-on request; any force stops it
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			dly_cnt_r <= '0;
			init_r    <= 1'b1;
		end
		else
		begin
			init_r <= 1'b0;
			if (evt_force)
				dly_cnt_r <= '0;
			else if (init_r || dly_load)
				dly_cnt_r <= delay_r;
			else
				dly_cnt_r <= count_down(dly_cnt_r, tick_r);
		end
	end
endmodule
`default_nettype wire

// ### verification/dof_checker.sv
// port assertions for the discrete output point
`timescale 1ns/10ps
`default_nettype none
module dof_checker
	import dof_pkg::*;
(
	// clock and reset
	input wire logic                      clock,
	input wire logic                      rstn,
	// bus handshake
	input wire logic                      avs_read,
	input wire logic                      avs_write,
	input wire logic                      avs_waitrequest,
	// force request and answer
	input wire logic                      force_valid,
	input wire logic [dof_pkg::LVL_W-1:0] force_level,
	input wire logic                      rsp_valid,
	input wire logic                      rsp_ack,
	input wire logic                      rsp_insuf,
	input wire logic                      do_out
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	chk_rsp_after_force: assert property (force_valid |=> rsp_valid)
		else $error("force got no answer strobe");
	chk_rsp_no_spur: assert property (!force_valid |=> !rsp_valid)
		else $error("answer strobe without force");
	chk_insuf_ack_hold: assert property (rsp_valid && rsp_ack && rsp_insuf |-> do_out == $past(do_out))
		else $error("turn-off applied while min-on ran");
	chk_nack_hold: assert property (rsp_valid && !rsp_ack |-> do_out == $past(do_out))
		else $error("rejected force changed output");
	chk_top_level_ack: assert property (force_valid && force_level == 4'h1 |=> rsp_ack && !rsp_insuf)
		else $error("level 1 force not acknowledged");
	chk_bad_level_ref: assert property (force_valid && (force_level == 4'h0 || force_level > LVL_LAST)
		|=> !rsp_ack && !rsp_insuf)
		else $error("illegal level not refused");
	chk_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	chk_bus_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
endmodule
bind dof_top dof_checker u_chk (.clock(clock), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .force_valid(force_valid), .force_level(force_level),
	.rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_insuf(rsp_insuf), .do_out(do_out));
`default_nettype wire

// ### verification/dof_net_src.sv
// network command source model: one-cycle forces and auto commands
`timescale 1ns/10ps
`default_nettype none
module dof_net_src
	import dof_pkg::*;
(
	// clock
	input  wire logic                      clock,
	// commands
	output logic                           force_valid,
	output logic [dof_pkg::LVL_W-1:0]      force_level,
	output logic                           force_state,
	output logic                           auto_cmd
);
	initial
	begin
		force_valid = 1'b0;
		force_level = 4'h0;
		force_state = 1'b0;
		auto_cmd    = 1'b0;
	end
	task automatic send(input logic [3:0] lvl, input logic st);
		@(posedge clock);
		force_valid <= 1'b1;
		force_level <= lvl;
		force_state <= st;
		@(posedge clock);
		force_valid <= 1'b0;
		// stale qualifiers so nothing leans on held values
		force_level <= ~lvl;
		force_state <= ~st;
	endtask
	task automatic auto_c();
		@(posedge clock);
		auto_cmd <= 1'b1;
		@(posedge clock);
		auto_cmd <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verification/dof_top_tb.sv
// self-checking bench for the discrete output point
`timescale 1ns/10ps
`default_nettype none
module dof_top_tb;
	import dof_pkg::*;
	// one second is ten cycles here to keep the run short
	localparam int TK = 10;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        alg_req = 1'b0;
	logic        force_valid;
	logic [3:0]  force_level;
	logic        force_state;
	logic        auto_cmd;
	logic        rsp_valid;
	logic        rsp_ack;
	logic        rsp_insuf;
	logic        do_out;
	logic [31:0] rd;
	int          n_fail = 0;
	int          check_count = 0;
	always #50 clock = ~clock;
	dof_top #(.TICK_CYCLES_P(TK)) u_dut (.clock(clock), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .alg_req(alg_req),
		.force_valid(force_valid), .force_level(force_level), .force_state(force_state),
		.auto_cmd(auto_cmd), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_insuf(rsp_insuf), .do_out(do_out));
	dof_net_src u_src (.clock(clock), .force_valid(force_valid), .force_level(force_level),
		.force_state(force_state), .auto_cmd(auto_cmd));
	task automatic cmp1(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= d;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic fchk(input logic [3:0] l, input logic s, input logic a, input logic i, input logic o);
		u_src.send(l, s);
		#1;
		cmp1("rsp_valid", 1'b1, rsp_valid);
		cmp1("rsp_ack", a, rsp_ack);
		cmp1("rsp_insuf", i, rsp_insuf);
		cmp1("do_out", o, do_out);
	endtask
	task automatic wait_out(input logic e);
		int n;
		n = 0;
		while (do_out !== e && n < 100)
		begin
			@(posedge clock);
			n++;
		end
		cmp1("do_out", e, do_out);
	endtask
	task automatic t_reset();
		for (int a = 0; a <= 24; a += 4)
		begin
			bus(1'b0, 5'(a), 32'h0000_0000);
			cmp32("reset read", 32'h0000_0000, rd);
		end
		bus(1'b1, 5'h18, 32'hFFFF_FFFF);
		bus(1'b0, 5'h18, 32'h0000_0000);
		cmp32("unmapped read", 32'h0000_0000, rd);
		bus(1'b1, REG_MIN_OFF, 32'h0000_FFFF);
		bus(1'b0, REG_MIN_OFF, 32'h0000_0000);
		cmp32("min-off clamp", 32'h0000_0E10, rd);
		bus(1'b1, REG_MIN_OFF, 32'h0000_0000);
		$display("t_reset done");
	endtask
	task automatic t_polarity();
		@(posedge clock);
		alg_req <= 1'b1;
		wait_out(1'b1);
		bus(1'b1, REG_CTRL, 32'h0000_0001);
		repeat (2) @(posedge clock);
		cmp1("inverted out", 1'b0, do_out);
		bus(1'b1, REG_CTRL, 32'h0000_0000);
		repeat (2) @(posedge clock);
		cmp1("normal out", 1'b1, do_out);
		alg_req <= 1'b0;
		wait_out(1'b0);
		$display("t_polarity done");
	endtask
	task automatic t_delay();
		bus(1'b1, REG_DELAY, 32'h0000_0002);
		alg_req <= 1'b1;
		repeat (5) @(posedge clock);
		cmp1("delayed out", 1'b0, do_out);
		wait_out(1'b1);
		alg_req <= 1'b0;
		wait_out(1'b0);
		bus(1'b1, REG_CTRL, 32'h0000_0004);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		cmp1("delay running", 1'b1, rd[ST_DLY_RUN]);
		fchk(4'h9, 1'b0, 1'b1, 1'b0, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		cmp1("delay stopped", 1'b0, rd[ST_DLY_RUN]);
		u_src.auto_c();
		bus(1'b1, REG_CTRL, 32'h0000_0004);
		bus(1'b1, REG_RETAIN, 32'h0000_0018);
		bus(1'b1, REG_CTRL, 32'h0000_0002);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		cmp1("retained delay stop", 1'b0, rd[ST_DLY_RUN]);
		cmp1("retained ack", 1'b1, rd[ST_ACK]);
		cmp1("retained out", 1'b1, do_out);
		u_src.auto_c();
		repeat (5) @(posedge clock);
		cmp1("held after auto", 1'b1, do_out);
		bus(1'b1, REG_DELAY, 32'h0000_0000);
		$display("t_delay done");
	endtask
	task automatic t_force();
		bus(1'b1, REG_MIN_ON, 32'h0000_0003);
		bus(1'b1, REG_MIN_OFF, 32'h0000_0003);
		fchk(4'h2, 1'b0, 1'b1, 1'b0, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		cmp1("min timers stopped", 1'b0, rd[ST_OFF_RUN] | rd[ST_ON_RUN]);
		u_src.auto_c();
		fchk(4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		fchk(4'h7, 1'b1, 1'b1, 1'b0, 1'b1);
		fchk(4'h7, 1'b0, 1'b1, 1'b1, 1'b1);
		fchk(4'h7, 1'b1, 1'b1, 1'b0, 1'b1);
		rd = 32'hFFFF_FFFF;
		for (int n = 0; n < 40 && rd[ST_ON_RUN] !== 1'b0; n++)
			bus(1'b0, REG_STATUS, 32'h0000_0000);
		cmp1("min-on expired", 1'b0, rd[ST_ON_RUN]);
		fchk(4'h7, 1'b0, 1'b1, 1'b0, 1'b0);
		fchk(4'h7, 1'b1, 1'b0, 1'b1, 1'b0);
		fchk(4'h7, 1'b0, 1'b1, 1'b0, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		cmp1("min-off running", 1'b1, rd[ST_OFF_RUN]);
		fchk(4'h1, 1'b1, 1'b1, 1'b0, 1'b1);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		cmp1("min-off stopped", 1'b0, rd[ST_OFF_RUN]);
		fchk(4'h9, 1'b0, 1'b0, 1'b1, 1'b1);
		$display("t_force done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		t_polarity();
		t_delay();
		t_force();
		report_and_stop();
	end
	initial
	begin
		#1_000_000;
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
